// ==== rtl/sclm_cc_decoder.sv ====
// Composite-clock receive decoder: finds violations and missing violations.
`include "sclm_defines.svh"
`default_nettype none
module sclm_cc_decoder (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Decoder channel.
  sclm_dec_if.dec  dec
);
  import sclm_pkg::*;
  logic       last_neg_q, last_neg_d;   // Polarity of last mark.
  logic [3:0] cnt_q, cnt_d;             // Bits since last violation or missing violation.
  logic       m8_q, m8_d;
  logic       m4_q, m4_d;

  // A mark with the same polarity as the previous one is a violation.
  always_comb begin
    last_neg_d = last_neg_q;
    cnt_d      = cnt_q;
    m8_d       = 1'b0;
    m4_d       = 1'b0;
    if (dec.strobe) begin
      if (dec.pos || dec.neg) begin
        last_neg_d = dec.neg;
      end
      if ((dec.pos && !last_neg_q) || (dec.neg && last_neg_q)) begin
        m8_d  = 1'b1;
        cnt_d = 4'h0;
      end else if (cnt_q == 4'(`SCLM_CC_BITS_PER_8K - 1)) begin
        m4_d  = 1'b1; // Expected violation absent.
        cnt_d = 4'h0;
      end else begin
        cnt_d = cnt_q + 4'h1;
      end
    end
  end

  // Registers only.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      last_neg_q <= 1'b0;
      cnt_q      <= 4'h0;
      m8_q       <= 1'b0;
      m4_q       <= 1'b0;
    end else begin
      last_neg_q <= last_neg_d;
      cnt_q      <= cnt_d;
      m8_q       <= m8_d;
      m4_q       <= m4_d;
    end
  end
  assign dec.mk_8k  = m8_q;
  assign dec.mk_400 = m4_q;

  AST_DEC_EXCL: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    !(m8_q && m4_q)) else $error("Both markers at once.");
endmodule // sclm_cc_decoder
`default_nettype wire

// ==== rtl/sclm_defines.svh ====
// Offsets, field positions, reset values and timing counts of the line-mode block.
`ifndef SCLM_DEFINES_SVH
`define SCLM_DEFINES_SVH
`define SCLM_LOOPBACK_CONTROL_ADDR 8'h20
`define SCLM_LOOPBACK_CONTROL_RST  8'h00
`define SCLM_REMOTE_LOOP_BIT       2
`define SCLM_LOCAL_LOOP_BIT        3
`define SCLM_CC_BITS_PER_8K        8
`define SCLM_CC_8K_PER_400         20
`define SCLM_SYNC_BITS             3
`endif

// ==== rtl/sclm_if.sv ====
// Interface carrying the composite-clock decoder signals.
`default_nettype none
interface sclm_dec_if;
  logic pos;    // Positive mark from line.
  logic neg;    // Negative mark from line.
  logic strobe; // One pulse per 64 kHz bit.
  logic mk_8k;  // Violation seen.
  logic mk_400; // Expected violation missing.
  modport top (output pos, output neg, output strobe, input mk_8k, input mk_400);
  modport dec (input pos, input neg, input strobe, output mk_8k, output mk_400);
endinterface
`default_nettype wire

// ==== rtl/sclm_line_top.sv ====
// Loopback paths, composite-clock and 6312 kHz line modes of the timing element.
`include "sclm_defines.svh"
`default_nettype none
module sclm_line_top #(
  parameter int BITS_PER_8K = `SCLM_CC_BITS_PER_8K, // 64 kHz bits per 8 kHz period.
  parameter int PER_400     = `SCLM_CC_8K_PER_400   // 8 kHz periods per 400 Hz period.
) (
  // Clock and reset.
  input  wire logic                i_ref_clk,
  input  wire logic                i_reset,
  // Register port.
  input  wire logic [7:0]          i_reg_addr,
  input  wire logic [7:0]          i_reg_wdata,
  input  wire logic                i_reg_wr,
  output logic      [7:0]          o_reg_rdata,
  // Mode controls.
  input  wire sclm_pkg::sclm_mode_t i_mode,
  input  wire logic                i_cc_400_en,
  input  wire logic                i_jitter_att_en,
  // Line-rate strobes and clocks.
  input  wire logic                i_bit_strobe,
  input  wire logic                i_rec_clk,
  input  wire logic                i_pll_clk,
  // Line interface, receive side.
  input  wire logic                i_rx_line_pos,
  input  wire logic                i_rx_line_neg,
  input  wire logic                i_rx_serial_data,
  input  wire logic                i_tx_8k_sync_in,
  // Formatter and jitter attenuator path.
  input  wire logic                i_fmt_pos,
  input  wire logic                i_fmt_neg,
  input  wire logic                i_ja_pos,
  input  wire logic                i_ja_neg,
  output logic                     o_ja_in_pos,
  output logic                     o_ja_in_neg,
  output logic                     o_framer_pos,
  output logic                     o_framer_neg,
  output logic                     o_rx_data,
  // Line interface, transmit side.
  output logic                     o_tx_line_pos,
  output logic                     o_tx_line_neg,
  output logic                     o_tx_line_oe_n,
  // Clock outputs.
  output logic                     o_rx_clock,
  output logic                     o_pll_out,
  output logic                     o_tx_clock_out,
  // Recovered composite-clock outputs.
  output logic                     o_rx_8k_sync_out,
  output logic                     o_rx_400_out,
  output logic                     o_rx_sync_oe_n
);
  import sclm_pkg::*;

  // Pin inputs pass two flops before use.
  logic [1:0] s_rp_q, s_rn_q, s_sd_q, s_sy_q, s_rc_q, s_pl_q;
  logic rp, rn, sd, sy, rc, pl;
  assign rp = s_rp_q[1];
  assign rn = s_rn_q[1];
  assign sd = s_sd_q[1];
  assign sy = s_sy_q[1];
  assign rc = s_rc_q[1];
  assign pl = s_pl_q[1];

  // Control register; only the two loop selects are kept, others read zero.
  logic remote_loop_enable_q, remote_loop_enable_d;
  logic local_loop_enable_q, local_loop_enable_d;

  // Composite-clock transmitter state.
  logic [3:0] tbit_q, tbit_d;     // Bit within 8 kHz period.
  logic [4:0] t8k_q, t8k_d;       // 8 kHz period within 400 Hz period.
  logic       tlast_neg_q, tlast_neg_d;
  logic       sync_prev_q, sync_prev_d;
  logic       sync_pend_q, sync_pend_d; // Sync edge held until the next bit strobe.
  logic       sync_hit;                 // Sync edge seen now or still pending.
  logic       cc_pos, cc_neg;

  // Registered outputs.
  logic [7:0] rdata_q, rdata_d;
  logic tp_q, tp_d, tn_q, tn_d, toe_q, toe_d;
  logic fp_q, fp_d, fn_q, fn_d, jp_q, jp_d, jn_q, jn_d, rd_q, rd_d;
  logic rck_q, rck_d, pll_q, pll_d, tck_q, tck_d;
  logic r8_q, r8_d, r4_q, r4_d, roe_q, roe_d;

  // Decoder for the composite-clock receive stream.
  sclm_dec_if dif ();
  sclm_cc_decoder u_dec (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .dec       (dif.dec)
  );
  assign dif.pos    = o_framer_pos;
  assign dif.neg    = o_framer_neg;
  assign dif.strobe = i_bit_strobe && (i_mode == SCLM_MODE_CC64);

  // Register write and readback.
  always_comb begin
    remote_loop_enable_d = remote_loop_enable_q;
    local_loop_enable_d  = local_loop_enable_q;
    if (i_reg_wr && i_reg_addr == `SCLM_LOOPBACK_CONTROL_ADDR) begin
      // Unused bits are expected zero; they are simply not stored.
      remote_loop_enable_d = i_reg_wdata[`SCLM_REMOTE_LOOP_BIT];
      local_loop_enable_d  = i_reg_wdata[`SCLM_LOCAL_LOOP_BIT];
    end
    rdata_d = 8'h00;
    if (i_reg_addr == `SCLM_LOOPBACK_CONTROL_ADDR) begin
      rdata_d[`SCLM_REMOTE_LOOP_BIT] = remote_loop_enable_q;
      rdata_d[`SCLM_LOCAL_LOOP_BIT]  = local_loop_enable_q;
    end
  end

  // Composite-clock encoder: AMI marks every bit, violation at bit 0.
  always_comb begin
    tbit_d      = tbit_q;
    t8k_d       = t8k_q;
    tlast_neg_d = tlast_neg_q;
    sync_prev_d = sy;
    // The sync edge lasts one cycle, so it is held until a strobe uses it.
    // The sync input is dropped in 6312 kHz mode.
    sync_hit    = sync_pend_q || (sy && !sync_prev_q && i_mode != SCLM_MODE_6312);
    sync_pend_d = sync_hit;
    cc_pos      = 1'b0;
    cc_neg      = 1'b0;
    if (i_bit_strobe) begin
      sync_pend_d = 1'b0;
      // A sync edge realigns the period at the next strobe; else it free-runs.
      if (sync_hit) begin
        tbit_d = 4'h0;
      end else if (tbit_q == 4'(BITS_PER_8K - 1)) begin
        tbit_d = 4'h0;
      end else begin
        tbit_d = tbit_q + 4'h1;
      end
      if (tbit_d == 4'h0) begin
        t8k_d = (t8k_q == 5'(PER_400 - 1)) ? 5'h0 : t8k_q + 5'h1;
      end
      // Violation repeats last polarity, omitted once per 400 Hz.
      if (tbit_d == 4'h0 && !(i_cc_400_en && t8k_d == 5'h0)) begin
        cc_neg = tlast_neg_q;
      end else begin
        cc_neg = !tlast_neg_q;
      end
      cc_pos      = !cc_neg;
      tlast_neg_d = cc_neg;
    end
  end

  // Data paths and mode-dependent outputs.
  always_comb begin
    tp_d = tp_q;
    tn_d = tn_q;
    toe_d = 1'b0;
    // Local loop feeds transmit data to the receive side.
    fp_d = local_loop_enable_q ? (i_jitter_att_en ? i_ja_pos : i_fmt_pos) : rp;
    fn_d = local_loop_enable_q ? (i_jitter_att_en ? i_ja_neg : i_fmt_neg) : rn;
    // Attenuator input takes transmit data in local loop.
    jp_d = local_loop_enable_q ? i_fmt_pos : rp;
    jn_d = local_loop_enable_q ? i_fmt_neg : rn;
    rd_d = sd;
    rck_d = rc;
    pll_d = pl;
    tck_d = pl;
    r8_d = dif.mk_8k;
    r4_d = dif.mk_400;
    roe_d = 1'b0;
    unique case (i_mode)
      SCLM_MODE_CC64: begin
        tp_d = cc_pos;
        tn_d = cc_neg;
        if (!i_bit_strobe) begin
          tp_d = 1'b0;
          tn_d = 1'b0;
        end
      end
      SCLM_MODE_6312: begin
        toe_d = 1'b1;  // Line pair floats.
        tp_d = 1'b0;
        tn_d = 1'b0;
        roe_d = 1'b1;
        r8_d = 1'b0;
        r4_d = 1'b0;
        rd_d = 1'b0;  // Serial data pin ignored.
        rck_d = rc;  // Recovered 6312 kHz square wave.
        pll_d = pl;
        tck_d = remote_loop_enable_q ? rc : pl;
      end
      SCLM_MODE_DIGITAL: begin
        tp_d = i_fmt_pos;
        tn_d = i_fmt_neg;
        r8_d = 1'b0;
        r4_d = 1'b0;
      end
      default: begin
        tp_d = 1'b0;
        tn_d = 1'b0;
      end
    endcase
    // Outside 6312 kHz mode, remote loop drives the line from receive, formatter dropped.
    if (remote_loop_enable_q && i_mode != SCLM_MODE_6312) begin
      tp_d = rp;
      tn_d = rn;
    end
  end

  // All registers.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      {s_rp_q, s_rn_q, s_sd_q, s_sy_q, s_rc_q, s_pl_q} <= 12'h000;
      remote_loop_enable_q <= 1'b0;
      local_loop_enable_q  <= 1'b0;
      tbit_q <= 4'h0;
      t8k_q <= 5'h00;
      tlast_neg_q <= 1'b0;
      sync_prev_q <= 1'b0;
      sync_pend_q <= 1'b0;
      rdata_q <= `SCLM_LOOPBACK_CONTROL_RST;
      {tp_q, tn_q, toe_q, fp_q, fn_q, jp_q, jn_q, rd_q} <= 8'h00;
      {rck_q, pll_q, tck_q, r8_q, r4_q, roe_q} <= 6'h00;
    end else begin
      s_rp_q <= {s_rp_q[0], i_rx_line_pos};
      s_rn_q <= {s_rn_q[0], i_rx_line_neg};
      s_sd_q <= {s_sd_q[0], i_rx_serial_data};
      s_sy_q <= {s_sy_q[0], i_tx_8k_sync_in};
      s_rc_q <= {s_rc_q[0], i_rec_clk};
      s_pl_q <= {s_pl_q[0], i_pll_clk};
      remote_loop_enable_q <= remote_loop_enable_d;
      local_loop_enable_q  <= local_loop_enable_d;
      tbit_q <= tbit_d;
      t8k_q <= t8k_d;
      tlast_neg_q <= tlast_neg_d;
      sync_prev_q <= sync_prev_d;
      sync_pend_q <= sync_pend_d;
      rdata_q <= rdata_d;
      {tp_q, tn_q, toe_q, fp_q, fn_q, jp_q, jn_q, rd_q} <=
        {tp_d, tn_d, toe_d, fp_d, fn_d, jp_d, jn_d, rd_d};
      {rck_q, pll_q, tck_q, r8_q, r4_q, roe_q} <=
        {rck_d, pll_d, tck_d, r8_d, r4_d, roe_d};
    end
  end

  assign o_reg_rdata      = rdata_q;
  assign o_tx_line_pos    = tp_q;
  assign o_tx_line_neg    = tn_q;
  assign o_tx_line_oe_n   = toe_q;
  assign o_framer_pos     = fp_q;
  assign o_framer_neg     = fn_q;
  assign o_ja_in_pos      = jp_q;
  assign o_ja_in_neg      = jn_q;
  assign o_rx_data        = rd_q;
  assign o_rx_clock       = rck_q;
  assign o_pll_out        = pll_q;
  assign o_tx_clock_out   = tck_q;
  assign o_rx_8k_sync_out = r8_q;
  assign o_rx_400_out     = r4_q;
  assign o_rx_sync_oe_n   = roe_q;

  // Assertions.
  sequence s_6312;
    i_mode == SCLM_MODE_6312;
  endsequence
  AST_TX_FLOAT: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    s_6312 |=> o_tx_line_oe_n) else $error("Line not floated.");
  AST_RX_FLOAT: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    s_6312 |=> o_rx_sync_oe_n) else $error("Sync out not floated.");
  AST_TCLK_MUX: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    s_6312 ##0 remote_loop_enable_q |=> o_tx_clock_out == $past(rc))
    else $error("Tx clock not recovered.");
  AST_TCLK_PLL: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    s_6312 ##0 !remote_loop_enable_q |=> o_tx_clock_out == o_pll_out)
    else $error("Tx clock not PLL.");
  AST_PLL_OUT: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    s_6312 |=> o_pll_out == $past(pl)) else $error("PLL output wrong.");
  AST_RCLK: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    s_6312 |=> o_rx_clock == $past(rc)) else $error("Rx clock wrong.");
  AST_RX_SERIAL_DATA_IGN: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    s_6312 |=> !o_rx_data) else $error("Serial data passed.");
  AST_REMOTE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (remote_loop_enable_q && i_mode != SCLM_MODE_6312) |=> o_tx_line_pos == $past(rp))
    else $error("Remote loop broken.");
  AST_LOCAL: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    local_loop_enable_q && !i_jitter_att_en |=> o_framer_pos == $past(i_fmt_pos))
    else $error("Local loop broken.");
  AST_LOCAL_JA: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    local_loop_enable_q && i_jitter_att_en |=> o_framer_pos == $past(i_ja_pos))
    else $error("Local loop skips attenuator.");
  AST_SYNC_ALIGN: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_bit_strobe && sync_hit |=> tbit_q == 4'h0) else $error("Sync edge not aligned.");
  AST_REG_RB: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_reg_wr && i_reg_addr == `SCLM_LOOPBACK_CONTROL_ADDR |=>
    remote_loop_enable_q == $past(i_reg_wdata[`SCLM_REMOTE_LOOP_BIT]))
    else $error("Remote select write lost.");
  AST_REG_LOC: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_reg_wr && i_reg_addr == `SCLM_LOOPBACK_CONTROL_ADDR |=>
    local_loop_enable_q == $past(i_reg_wdata[`SCLM_LOCAL_LOOP_BIT]))
    else $error("Local select write lost.");
endmodule // sclm_line_top
`default_nettype wire

// ==== rtl/sclm_pkg.sv ====
// Types shared by the line-mode block.
`default_nettype none
package sclm_pkg;
  // Line mode selection.
  typedef enum logic [1:0] {
    SCLM_MODE_DIGITAL,
    SCLM_MODE_CC64,
    SCLM_MODE_6312
  } sclm_mode_t;
endpackage
`default_nettype wire

// ==== verification/sclm_line_model.sv ====
// Line interface model that sends a composite-clock AMI stream toward the receive pins.
`default_nettype none
module sclm_line_model #(
  parameter int BITS = 8, // Marks per 8 kHz period.
  parameter int SKIP = 20 // Periods per 400 Hz period.
) (
  // Bench side.
  input  wire logic i_clk,
  input  wire logic i_step,
  input  wire logic i_skip_en,
  // Line side.
  output var logic  o_pos,
  output var logic  o_neg
);
  timeunit 1ns;
  timeprecision 1ps;
  int   bit_n = 0;    // Mark number within the 8 kHz period.
  int   per_n = 0;    // Period number within the 400 Hz cycle.
  logic pol   = 1'b0; // Polarity of the last mark, high for positive.

  // Bit 0 of a period repeats the last polarity, except once per SKIP periods.
  // The pair returns to zero after a quarter bit, so a repeated polarity stays visible.
  // One process drives the pair, so the idle level and the marks never race.
  initial begin
    o_pos = 1'b0;
    o_neg = 1'b0;
    forever begin
      @(posedge i_clk);
      if (i_step) begin
        if (bit_n != 0 || (i_skip_en && per_n == 0)) pol = ~pol;
        #1;
        o_pos = pol;
        o_neg = ~pol;
        bit_n = (bit_n + 1) % BITS;
        if (bit_n == 0) per_n = (per_n + 1) % SKIP;
        repeat (4) @(posedge i_clk);
        #1;
        o_pos = 1'b0;
        o_neg = 1'b0;
      end
    end
  end
endmodule // sclm_line_model
`default_nettype wire

// ==== verification/sclm_line_top_tb_top.sv ====
// Self-checking bench for the loopback and line-mode block.
`default_nettype none
module sclm_line_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sclm_pkg::*;
  // Stimulus.
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, run = 1'b0, stb = 1'b0, mdl = 1'b0;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
  sclm_mode_t  mode = SCLM_MODE_DIGITAL;
  logic        c400 = 1'b0, ja_en = 1'b0, rec = 1'b0, pll = 1'b0, ser = 1'b0, sync = 1'b0;
  logic        fp = 1'b0, fn = 1'b0, jp = 1'b0, jn = 1'b0, rp = 1'b0, rn = 1'b0;
  logic [3:0]  scnt = 4'h0; // Divider for the bit strobe.
  logic        mstb = 1'b0; // Model step, five cycles ahead of the bit strobe.
  logic [23:0] ev;          // Expected value being built.
  // Observed outputs.
  logic        mp, mn, rxp, rxn, jip, jin, frp, frn, rxd, txp, txn, txoe;
  logic        rclk, pout, tclk, s8k, s400, soe, pp = 1'b0, pn = 1'b0, lastp = 1'b0;
  logic [23:0] obs;
  // Scoreboard.
  logic [47:0] notes[$]; // Pending expectations, mask above value.
  logic [47:0] nt;
  logic        chk = 1'b0;
  int          error_cnt = 0, n_compared = 0, seed = 32'hDF33, r, n8k = 0, n400 = 0, nviol = 0;
  int          nmark = 0, v0 = 0, m0 = 0; // Transmitted marks and snapshots.

  assign rxp = mdl ? mp : rp;
  assign rxn = mdl ? mn : rn;
  assign obs = {rdata, txp, txn, txoe, frp, frn, jip, jin, soe, rclk, pout, tclk, rxd, 4'h0};

  initial begin
    forever #4 clk = ~clk;
  end

  sclm_line_top i_sclm_line_top (
    .i_ref_clk(clk), .i_reset(rst), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .o_reg_rdata(rdata), .i_mode(mode), .i_cc_400_en(c400),
    .i_jitter_att_en(ja_en), .i_bit_strobe(stb), .i_rec_clk(rec), .i_pll_clk(pll),
    .i_rx_line_pos(rxp), .i_rx_line_neg(rxn), .i_rx_serial_data(ser),
    .i_tx_8k_sync_in(sync), .i_fmt_pos(fp), .i_fmt_neg(fn), .i_ja_pos(jp), .i_ja_neg(jn),
    .o_ja_in_pos(jip), .o_ja_in_neg(jin), .o_framer_pos(frp), .o_framer_neg(frn),
    .o_rx_data(rxd), .o_tx_line_pos(txp), .o_tx_line_neg(txn), .o_tx_line_oe_n(txoe),
    .o_rx_clock(rclk), .o_pll_out(pout), .o_tx_clock_out(tclk),
    .o_rx_8k_sync_out(s8k), .o_rx_400_out(s400), .o_rx_sync_oe_n(soe));

  sclm_line_model #(.BITS(8), .SKIP(20)) i_sclm_line_model (
    .i_clk(clk), .i_step(mstb), .i_skip_en(c400), .o_pos(mp), .o_neg(mn));

  // One strobe every sixteen cycles stands in for the 64 kHz bit rate.
  // The line model steps five cycles earlier, so a mark has crossed the pin
  // synchroniser and the framer flop when the decoder samples it at the strobe.
  always @(posedge clk) begin
    scnt <= scnt + 4'h1;
    stb  <= #1 (run && scnt == 4'hF);
    mstb <= #1 (run && scnt == 4'hA);
  end

  // Takes the oldest note whenever the bench marks a settled result.
  always @(posedge clk) begin
    if (chk && notes.size() > 0) begin
      nt = notes.pop_front();
      check(obs & nt[47:24], nt[23:0]);
    end
  end

  // Counts recovered markers, and transmitted marks that repeat the last polarity.
  always @(posedge clk) begin
    if (s8k === 1'b1) n8k++;
    if (s400 === 1'b1) n400++;
    if ((txp === 1'b1 && !pp) || (txn === 1'b1 && !pn)) begin
      nmark++;
      if (txp == lastp) nviol++;
      lastp = txp;
    end
    pp = (txp === 1'b1);
    pn = (txn === 1'b1);
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic note_exp(input logic [23:0] m, input logic [23:0] v);
    notes.push_back({m, v});
    chk = 1'b1;
    tick(1);
    chk = 1'b0;
  endtask

  task automatic wreg(input logic [7:0] d);
    addr  = 8'h20;
    wdata = d;
    wr    = 1'b1;
    tick(1);
    wr    = 1'b0;
    tick(3);
  endtask

  task automatic wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Bounds the whole run; a hang counts as a mismatch.
  initial begin
    #200000;
    error_cnt++;
    wrap_up();
  end

  // Register access, then each loop path, then each line mode.
  initial begin
    tick(16);
    rst  = 1'b0;
    addr = 8'h20;
    tick(3);
    note_exp(24'hFF0000, 24'h000000);
    wreg(8'h0C);
    note_exp(24'hFF0000, 24'h0C0000);
    addr = 8'h21;
    tick(3);
    note_exp(24'hFF0000, 24'h000000);
    wreg(8'h04);
    for (int i = 0; i < 8; i++) begin
      r  = $random(seed);
      rp = r[0];
      rn = ~r[0];
      fp = r[1];
      fn = r[2];
      ser = r[3];
      tick(6);
      note_exp(24'h00F810, {8'h00, rp, rn, 1'b0, rp, rn, 6'h00, ser, 4'h0});
    end
    wreg(8'h08);
    for (int i = 0; i < 8; i++) begin
      r     = $random(seed);
      ja_en = i[2];
      rp    = r[0];
      rn    = r[1];
      fp    = r[2];
      fn    = ~r[2];
      jp    = r[3];
      jn    = ~r[3];
      tick(6);
      if (!ja_en) note_exp(24'h00D800, {8'h00, fp, fn, 1'b0, fp, fn, 11'h000});
      else note_exp(24'h001E00, {11'h000, jp, jn, fp, fn, 9'h000});
    end
    wreg(8'h00);
    mode = SCLM_MODE_6312;
    for (int i = 0; i < 8; i++) begin
      if (i == 4) wreg(8'h04);
      r    = $random(seed);
      rec  = i[0];
      pll  = i[1];
      ser  = r[0];
      sync = r[1];
      rp   = r[2];
      rn   = r[3];
      tick(6);
      ev = {10'h000, 1'b1, 4'h0, 1'b1, rec, pll, i[2] ? rec : pll, 5'h00};
      note_exp(24'h0021F0, ev);
    end
    wreg(8'h00);
    sync = 1'b0;
    mode = SCLM_MODE_CC64;
    mdl  = 1'b1;
    run  = 1'b1;
    for (int v = 0; v < 2; v++) begin
      c400 = v[0];
      tick(512);
      n8k   = 0;
      n400  = 0;
      nviol = 0;
      tick(5120);
      check({23'h0, n8k >= 39 - 2 * v && n8k <= 41 - 2 * v}, 24'h1);
      check({23'h0, n400 >= v && n400 <= 2 * v}, 24'h1);
      check({23'h0, nviol >= 39 - 2 * v && nviol <= 41 - 2 * v}, 24'h1);
      note_exp(24'h002100, 24'h000000);
    end
    // A sync edge at a random phase must put the very next mark on a violation.
    // Three cycles after the pin rises the edge has reached the encoder, and the
    // following sixteen cycles hold exactly one bit strobe.
    c400 = 1'b0;
    for (int k = 0; k < 4; k++) begin
      r    = $random(seed);
      tick(40 + r[5:0]);
      sync = 1'b1;
      tick(3);
      v0   = nviol;
      m0   = nmark;
      tick(16);
      check({23'h0, nviol - v0 == 1 && nmark - m0 == 1}, 24'h1);
      sync = 1'b0;
    end
    wrap_up();
  end
endmodule // sclm_line_top_tb_top
`default_nettype wire
